// ---- rtl/ipv_pkg.sv ----
// Constants for the interrupt priority and vectoring controller
`default_nettype none

package ipv_pkg;

  // Source count and grouping
  localparam int unsigned NUM_SRC = 14;
  localparam int unsigned NUM_GROUP = 6;
  localparam int unsigned NUM_EXT = 3;
  localparam int unsigned NUM_PC = 8;
  localparam int unsigned NUM_PERIPH = 10;
  localparam int unsigned NUM_LEVEL = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EDGE_SEL = 8'ha4;
  localparam logic [7:0] IDX_EN_MAIN = 8'ha8;
  localparam logic [7:0] IDX_EN_SECOND = 8'ha9;
  localparam logic [7:0] IDX_EN_THIRD = 8'haa;
  localparam logic [7:0] IDX_PRIO_LO = 8'hb8;
  localparam logic [7:0] IDX_EXT_FLAGS = 8'hc0;
  localparam logic [7:0] IDX_PRIO_HI = 8'hf8;
  localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
  localparam logic [7:0] IDX_PC_ENABLE = 8'hd0;
  localparam logic [7:0] IDX_PC_FLAGS = 8'hd1;
  localparam logic [7:0] IDX_PENDING = 8'hd8;
  localparam logic [7:0] IDX_STATUS = 8'hd9;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [13:0] RST_PEND = 14'h0000;

  // Field layout
  localparam int unsigned GIE_BIT = 7;
  localparam logic [7:0] MASK_EN_MAIN = 8'hbf;
  localparam logic [7:0] MASK_SIX = 8'h3f;
  localparam logic [7:0] MASK_TWO = 8'h03;
  localparam logic [7:0] MASK_EXT_FLAGS = 8'h07;

  // Vector generation: base of the first maskable source, eight bytes apart
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam int unsigned VEC_SHIFT = 3;

  // Edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Request sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_REQ = 1'b1
  } ipv_state_type;

endpackage : ipv_pkg

`default_nettype wire

// ---- rtl/ipv_ctrl.sv ----
// Interrupt controller: masking, four-level priority, nesting and vector generation
//
// Contract
// - Fourteen maskable sources, vectors from 03h upward in eight byte steps.
// - A served request makes the core perform a long call to its vector.
// - Accept only when global enable and the source enable are both one.
// - Request flag sets on request, holds until accepted, clears on service.
// - Latched request stays until accepted, reset, or cleared by software.
// - Sample at last instruction cycle; accepted request replaces next fetch.
// - Low vector byte decided at detection; core acknowledges next first cycle.
// - Entry into the service routine takes 3 to 9 machine cycles.
// - Return from service ends that level so waiting requests may proceed.
// - Each group is set to one of four levels, 3 highest.
// - Simultaneous requests of different levels: higher level served first.
// - Running routine preempted only by a strictly higher level.
// - Same level ties go to the lower source number.
// - Any enabled pending source raises wakeup regardless of level.
// - Acceptance held off during writes to enable, priority, power registers.
// - External pins select rising, falling or both; reset means none.
// - External flag set on selected edge, cleared on service or write zero.
// - Pin change port requests on both edges, per pin enable and flag.
// - Third enable: interval timer bit 1, watchdog bit 0.
// - Both priority registers reset to zero, lowest level.
// - Group k level from bit k of both priority registers.
// - High register bit is level MSB, low register bit is LSB.
// - Edge code 00 none, 01 rising, 10 falling, 11 both.
// - Global enable clears on vector jump, sets on return from service.
`timescale 1ns/100ps
`default_nettype none

module ipv_ctrl (
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins and peripheral requests
  input wire logic [ipv_pkg::NUM_EXT-1:0] i_ext_pin,
  input wire logic [ipv_pkg::NUM_PC-1:0] i_pc_pin,
  input wire logic [ipv_pkg::NUM_PERIPH-1:0] i_periph_req,
  // Core sequencer
  input wire logic i_instr_last,
  input wire logic i_ack,
  input wire logic i_svc_return,
  output logic o_int_req,
  output logic [7:0] o_vector_low,
  output logic o_long_call,
  output logic o_wakeup
);
  import ipv_pkg::*;

  // Registers
  logic [7:0] edge_sel, en_main, en_second, en_third, prio_lo, prio_hi;
  logic [7:0] power_ctrl, pc_enable, pc_flags;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_LEVEL-1:0] in_service;
  logic [3:0] sel;
  ipv_state_type state;
  logic [NUM_EXT+NUM_PC-1:0] sync1, sync2, sync3, filt;
  logic [7:0] next_edge_sel, next_en_main, next_en_second, next_en_third;
  logic [7:0] next_prio_lo, next_prio_hi, next_power_ctrl, next_pc_enable, next_pc_flags;
  logic [NUM_SRC-1:0] next_pend;
  logic [NUM_LEVEL-1:0] next_in_service;
  logic [3:0] next_sel;
  ipv_state_type next_state;
  logic [NUM_EXT+NUM_PC-1:0] next_filt;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_int_req, next_long_call, next_wakeup;
  logic [7:0] next_vector_low;

  // Decoded bus terms
  logic [7:0] idx;
  logic setup, wr_done, hit;
  logic [7:0] wbyte, rbyte;
  logic cfg_write;

  // Request terms
  logic [NUM_EXT+NUM_PC-1:0] rise, fall;
  logic [NUM_EXT-1:0] ext_req;
  logic [NUM_PC-1:0] pc_ev;
  logic [NUM_SRC-1:0] req_vec, en_vec, elig;
  logic [1:0] lvl [NUM_SRC];
  logic [1:0] top_lvl, best_lvl;
  logic any_isr, found;
  logic [3:0] best_src;
  logic [NUM_LEVEL-1:0] top_onehot;

  // Bus decode; zero wait, so pready rises on the first access cycle
  assign idx = i_paddr[9:2];
  assign setup = i_psel && !i_penable;
  assign wr_done = i_psel && i_penable && o_pready && i_pwrite;
  assign wbyte = i_pwdata[7:0];
  assign cfg_write = wr_done && (idx == IDX_EN_MAIN || idx == IDX_EN_SECOND ||
                     idx == IDX_EN_THIRD || idx == IDX_PRIO_LO ||
                     idx == IDX_PRIO_HI || idx == IDX_POWER_CTRL);

  // Edge detect on the filtered pin levels; a change counts once two stages agree
  assign rise = sync2 & sync3 & ~filt;
  assign fall = ~sync2 & ~sync3 & filt;
  assign next_filt = (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & filt);

  // Per pin edge qualification from the two-bit polarity codes
  genvar gp;
  generate
    for (gp = 0; gp < NUM_EXT; gp++) begin : g_ext
      logic [1:0] code;
      assign code = edge_sel[2*gp +: 2];
      assign ext_req[gp] = ((code == EDGE_RISE || code == EDGE_BOTH) && rise[gp]) ||
                           ((code == EDGE_FALL || code == EDGE_BOTH) && fall[gp]);
    end
  endgenerate

  // Pin change port reacts to either edge on enabled pins
  assign pc_ev = (rise[NUM_EXT +: NUM_PC] | fall[NUM_EXT +: NUM_PC]) & pc_enable;

  assign req_vec = {i_periph_req, |pc_ev, ext_req};
  assign en_vec = {en_third[1:0], en_second[5:0], en_main[5:0]};

  // Group level per source: group is source number modulo six
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SRC; gs++) begin : g_src
      assign lvl[gs] = {prio_hi[gs % NUM_GROUP], prio_lo[gs % NUM_GROUP]};
      assign elig[gs] = pend[gs] && en_vec[gs] && en_main[GIE_BIT] &&
                        (!any_isr || lvl[gs] > top_lvl);
    end
  endgenerate

  // Highest level currently in service
  always_comb begin
    any_isr = |in_service;
    top_lvl = 2'h0;
    top_onehot = '0;
    for (int l = 0; l < NUM_LEVEL; l++) begin
      if (in_service[l]) begin
        top_lvl = 2'(l);
      end
    end
    if (any_isr) begin
      top_onehot[top_lvl] = 1'b1;
    end
  end

  // Scan from the top so that a lower number wins a tie at the same level
  always_comb begin
    found = 1'b0;
    best_lvl = 2'h0;
    best_src = 4'h0;
    for (int n = NUM_SRC - 1; n >= 0; n--) begin
      if (elig[n] && (!found || lvl[n] >= best_lvl)) begin
        found = 1'b1;
        best_lvl = lvl[n];
        best_src = 4'(n);
      end
    end
  end

  // Read mux; unused bits come back as zero
  always_comb begin
    hit = 1'b1;
    rbyte = RST_BYTE;
    case (idx)
      IDX_EDGE_SEL: rbyte = edge_sel;
      IDX_EN_MAIN: rbyte = en_main;
      IDX_EN_SECOND: rbyte = en_second;
      IDX_EN_THIRD: rbyte = en_third;
      IDX_PRIO_LO: rbyte = prio_lo;
      IDX_PRIO_HI: rbyte = prio_hi;
      IDX_EXT_FLAGS: rbyte = {5'h00, pend[NUM_EXT-1:0]};
      IDX_POWER_CTRL: rbyte = power_ctrl;
      IDX_PC_ENABLE: rbyte = pc_enable;
      IDX_PC_FLAGS: rbyte = pc_flags;
      IDX_PENDING: rbyte = 8'hff; // Wide register, handled below
      IDX_STATUS: rbyte = {in_service, sel};
      default: hit = 1'b0;
    endcase
  end

  // Next state of everything software or hardware touches
  always_comb begin
    next_edge_sel = edge_sel;
    next_en_main = en_main;
    next_en_second = en_second;
    next_en_third = en_third;
    next_prio_lo = prio_lo;
    next_prio_hi = prio_hi;
    next_power_ctrl = power_ctrl;
    next_pc_enable = pc_enable;
    next_pc_flags = pc_flags;
    next_pend = pend;
    next_in_service = in_service;
    next_sel = sel;
    next_state = state;
    next_int_req = o_int_req;
    next_vector_low = o_vector_low;
    next_long_call = 1'b0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;

    // Bus answer registered in the setup cycle
    if (setup) begin
      next_pready = 1'b1;
      next_pslverr = !hit;
      if (idx == IDX_PENDING) begin
        next_prdata = {18'h00000, pend};
      end else begin
        next_prdata = {24'h000000, rbyte};
      end
    end

    // Software writes; reserved bits are masked off
    if (wr_done) begin
      case (idx)
        IDX_EDGE_SEL: next_edge_sel = wbyte & MASK_SIX;
        IDX_EN_MAIN: next_en_main = wbyte & MASK_EN_MAIN;
        IDX_EN_SECOND: next_en_second = wbyte & MASK_SIX;
        IDX_EN_THIRD: next_en_third = wbyte & MASK_TWO;
        IDX_PRIO_LO: next_prio_lo = wbyte & MASK_SIX;
        IDX_PRIO_HI: next_prio_hi = wbyte & MASK_SIX;
        IDX_POWER_CTRL: next_power_ctrl = wbyte;
        IDX_PC_ENABLE: next_pc_enable = wbyte;
        IDX_PC_FLAGS: next_pc_flags = pc_flags & wbyte;
        IDX_EXT_FLAGS: next_pend[NUM_EXT-1:0] = pend[NUM_EXT-1:0] & wbyte[NUM_EXT-1:0];
        IDX_PENDING: next_pend = pend & i_pwdata[NUM_SRC-1:0];
        default: next_pend = next_pend;
      endcase
    end

    // Sequencer: sample at the last instruction cycle, wait for acknowledge
    case (state)
      ST_IDLE: begin
        if (i_instr_last && found && !cfg_write) begin
          next_state = ST_REQ;
          next_sel = best_src;
          next_int_req = 1'b1;
          next_vector_low = VEC_BASE + (8'(best_src) << VEC_SHIFT);
        end
      end
      ST_REQ: begin
        if (i_ack) begin
          next_state = ST_IDLE;
          next_int_req = 1'b0;
          next_long_call = 1'b1;
          next_pend[sel] = 1'b0;
          next_in_service[lvl[sel]] = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_int_req = 1'b0;
      end
    endcase

    // Return ends the deepest level and reopens global enable
    if (i_svc_return) begin
      next_in_service = next_in_service & ~top_onehot;
      next_en_main[GIE_BIT] = 1'b1;
    end
    if (state == ST_REQ && i_ack) begin
      next_en_main[GIE_BIT] = 1'b0;
    end

    // New events set last, so a set beats a clear in the same cycle
    next_pend = next_pend | req_vec;
    next_pc_flags = next_pc_flags | pc_ev;
  end

  // Wakeup ignores levels and global enable; any enabled pending source counts
  assign next_wakeup = |(next_pend & en_vec);

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end else begin
      sync1 <= {i_pc_pin, i_ext_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_sel <= RST_BYTE;
      en_main <= RST_BYTE;
      en_second <= RST_BYTE;
      en_third <= RST_BYTE;
      prio_lo <= RST_BYTE;
      prio_hi <= RST_BYTE;
      power_ctrl <= RST_BYTE;
      pc_enable <= RST_BYTE;
      pc_flags <= RST_BYTE;
      pend <= RST_PEND;
      in_service <= '0;
      sel <= 4'h0;
      state <= ST_IDLE;
      o_int_req <= 1'b0;
      o_vector_low <= RST_BYTE;
      o_long_call <= 1'b0;
      o_wakeup <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      edge_sel <= next_edge_sel;
      en_main <= next_en_main;
      en_second <= next_en_second;
      en_third <= next_en_third;
      prio_lo <= next_prio_lo;
      prio_hi <= next_prio_hi;
      power_ctrl <= next_power_ctrl;
      pc_enable <= next_pc_enable;
      pc_flags <= next_pc_flags;
      pend <= next_pend;
      in_service <= next_in_service;
      sel <= next_sel;
      state <= next_state;
      o_int_req <= next_int_req;
      o_vector_low <= next_vector_low;
      o_long_call <= next_long_call;
      o_wakeup <= next_wakeup;
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // Checks
  a_ack_ends_req: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_int_req && i_ack |=> !o_int_req && o_long_call)
    else $error("acknowledge did not end request with a long call");

  a_call_drops_gie: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_long_call |-> !en_main[GIE_BIT])
    else $error("global enable still set after vector jump");

  a_return_sets_gie: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_svc_return && !(o_int_req && i_ack) |=> en_main[GIE_BIT])
    else $error("return did not restore global enable");

  a_req_on_sample: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(o_int_req) |-> $past(i_instr_last) && $past(en_main[GIE_BIT]))
    else $error("request raised outside last instruction cycle");

  a_vector_value: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(o_int_req) |-> o_vector_low == VEC_BASE + (8'(sel) << VEC_SHIFT) && pend[sel])
    else $error("vector does not match selected pending source");

  a_hold_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_int_req && cfg_write |=> !o_int_req)
    else $error("request accepted during configuration write");

  a_preempt_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(o_int_req) && $past(any_isr) |-> lvl[sel] > $past(top_lvl))
    else $error("preemption by equal or lower level");

  a_ext_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ext_req[0] |=> pend[0])
    else $error("external pin flag not set on selected edge");

  a_apb_answer: assert property (@(posedge i_clk) disable iff (!i_resetn)
    setup |=> o_pready ##1 !o_pready)
    else $error("bus answer not exactly one cycle after setup");

endmodule // ipv_ctrl

`default_nettype wire

// ---- tb/ipv_core_model.sv ----
// Behavioural model of the core sequencer that answers the interrupt controller
`timescale 1ns/100ps
`default_nettype none

module ipv_core_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_int_req,
  input wire logic i_slow,
  input wire logic i_return_go,
  output logic o_instr_last,
  output logic o_ack,
  output logic o_svc_return
);
  logic [1:0] phase;
  logic [3:0] wt;

  // Four-cycle instructions; ack waits 1 or 8 cycles to mimic long ones
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase <= 2'h0;
      wt <= 4'h0;
      o_instr_last <= 1'b0;
      o_ack <= 1'b0;
      o_svc_return <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      o_instr_last <= (phase == 2'h2);
      o_svc_return <= i_return_go;
      wt <= i_int_req ? wt + 4'h1 : 4'h0;
      // Single pulse: wt moves past the match after it
      o_ack <= i_int_req && !o_ack && (wt == (i_slow ? 4'h8 : 4'h1));
    end
  end
endmodule // ipv_core_model

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the interrupt priority and vectoring controller
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ipv_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] ext = 3'h0;
  logic [7:0] pc = 8'h00;
  logic [9:0] preq = 10'h000;
  logic instr_last, ack, svc_return, int_req, long_call, wake;
  logic [7:0] vec;
  logic slow = 1'b0;
  logic return_go = 1'b0;
  logic [31:0] r;
  logic e;
  int failures = 0;
  int check_count = 0;
  localparam logic [7:0] RG [7] = '{IDX_EDGE_SEL, IDX_EN_MAIN, IDX_EN_SECOND,
    IDX_EN_THIRD, IDX_PRIO_LO, IDX_EXT_FLAGS, IDX_PRIO_HI};
  // Readback after writing all ones; flags ignore ones
  localparam logic [7:0] MK [7] = '{8'h3f, 8'hbf, 8'h3f, 8'h03, 8'h3f, 8'h00, 8'h3f};

  always #4 clk = ~clk;

  ipv_ctrl uut (.i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_pin(ext), .i_pc_pin(pc),
    .i_periph_req(preq), .i_instr_last(instr_last), .i_ack(ack), .i_svc_return(svc_return),
    .o_int_req(int_req), .o_vector_low(vec), .o_long_call(long_call), .o_wakeup(wake));

  ipv_core_model core (.i_clk(clk), .i_resetn(rstn), .i_int_req(int_req),
    .i_slow(slow), .i_return_go(return_go), .o_instr_last(instr_last), .o_ack(ack),
    .o_svc_return(svc_return));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    check_count++;
    if (seen !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 50) failures++;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] x);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), r, x);
  endtask

  task automatic pulse(input logic [9:0] m);
    preq <= m;
    @(posedge clk);
    preq <= 10'h000;
  endtask

  task automatic settle();
    repeat (10) @(posedge clk);
  endtask

  // Waits for the request, checks its vector, then the long call pulse
  task automatic expect_vec(input logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (int_req !== 1'b1 && n < 200);
    chk("vector", vec, v);
    do begin
      @(posedge clk);
      n++;
    end while (long_call !== 1'b1 && n < 200);
    chk("long call", long_call, 1'b1);
  endtask

  task automatic do_return();
    @(posedge clk);
    return_go <= 1'b1;
    @(posedge clk);
    return_go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    settle();
    foreach (RG[i]) begin
      rchk(RG[i], 32'h0);
      wr(RG[i], 8'hff);
      rchk(RG[i], {24'h0, MK[i]});
      wr(RG[i], 8'h00);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", e, 1'b1);
    // Request latched while masked, then released by the enables
    wr(IDX_EN_MAIN, 8'h10);
    wr(IDX_EN_MAIN, 8'h00);
    pulse(10'h001);
    settle();
    rchk(IDX_PENDING, 32'h10);
    chk("wake off", wake, 1'b0);
    wr(IDX_EN_MAIN, 8'h10);
    settle();
    chk("wake on", wake, 1'b1);
    chk("masked", int_req, 1'b0);
    wr(IDX_EN_MAIN, 8'h90);
    expect_vec(8'h23);
    rchk(IDX_EN_MAIN, 32'h10);
    rchk(IDX_PENDING, 32'h0);
    do_return();
    rchk(IDX_EN_MAIN, 32'h90);
    // Level 3 on group 5 beats level 0; nesting blocked until return
    wr(IDX_PRIO_LO, 8'h20);
    wr(IDX_PRIO_HI, 8'h20);
    wr(IDX_EN_MAIN, 8'hb0);
    pulse(10'h003);
    expect_vec(8'h2b);
    wr(IDX_EN_MAIN, 8'hb0);
    repeat (20) @(posedge clk);
    chk("no nest", int_req, 1'b0);
    do_return();
    expect_vec(8'h23);
    do_return();
    wr(IDX_PRIO_HI, 8'h00);
    // Equal level goes by source number; group 1 raised reverses it
    slow <= 1'b1;
    wr(IDX_EN_SECOND, 8'h03);
    // Third pass: group 0 on the high bit alone outranks group 1 on the low bit
    for (int k = 0; k < 3; k++) begin
      wr(IDX_PRIO_LO, k ? 8'h02 : 8'h00);
      wr(IDX_PRIO_HI, (k == 2) ? 8'h01 : 8'h00);
      pulse(10'h00c);
      expect_vec((k == 1) ? 8'h3b : 8'h33);
      do_return();
      expect_vec((k == 1) ? 8'h33 : 8'h3b);
      do_return();
    end
    slow <= 1'b0;
    // Falling-edge select on pin 1 ignores the rise; flag cleared by zero write
    wr(IDX_EN_MAIN, 8'h00);
    wr(IDX_EDGE_SEL, 8'h08);
    ext <= 3'h2;
    settle();
    rchk(IDX_EXT_FLAGS, 32'h0);
    ext <= 3'h0;
    settle();
    rchk(IDX_EXT_FLAGS, 32'h2);
    wr(IDX_EXT_FLAGS, 8'h00);
    rchk(IDX_EXT_FLAGS, 32'h0);
    // Rising edge on pin 0 served; service clears its flag
    wr(IDX_PENDING, 8'h00);
    wr(IDX_EDGE_SEL, 8'h01);
    wr(IDX_EN_MAIN, 8'h81);
    ext <= 3'h1;
    expect_vec(8'h03);
    rchk(IDX_EXT_FLAGS, 32'h0);
    do_return();
    // Pin change flags on both edges
    wr(IDX_PC_ENABLE, 8'h01);
    pc <= 8'h01;
    settle();
    rchk(IDX_PC_FLAGS, 32'h1);
    wr(IDX_PC_FLAGS, 8'h00);
    pc <= 8'h00;
    settle();
    rchk(IDX_PC_FLAGS, 32'h1);
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
